// file: design/pdaf_defs.svh
// port d alternate function override: constants shared by the design files
// assumes it is included once per compilation unit by its bare name
// Summary of operation
// - pin 6 carries timer0 compare a only while its direction bit is one
// - pin 5 carries timer0 compare b only while its direction bit is one
// - pin 3 carries timer2 compare b only while its direction bit is one
// - the same pins carry the timer waveforms in pwm modes
// - pin 5 input feeds timer1 external count source
// - pin 4 feeds timer0 count and serial clock; master mode drives clock out only while its direction bit is one
// - pin 3 input feeds external interrupt one
// - pin 2 input feeds external interrupt zero
// - pin 3 buffer on when irq one enabled or source 19 and group 2 on
// - pin 2 buffer on when irq zero enabled or source 18 and group 1 on
// - all eight pins are pin-change sources 16..23, buffer on with mask and group
// - transmitter enabled forces pin 1 to output with transmit data
// - receiver enabled forces pin 0 to input and feeds the receiver
// - forced input pin 0 keeps pull-up from its value bit unless globally off
// - global pull-up off disables every port pull-up
`ifndef PDAF_DEFS_SVH
`define PDAF_DEFS_SVH
`define PDAF_NPINS      8
`define PDAF_BIT_RX     3'h0
`define PDAF_BIT_TX     3'h1
`define PDAF_BIT_IRQ0   3'h2
`define PDAF_BIT_IRQ1   3'h3
`define PDAF_BIT_XCK    3'h4
`define PDAF_BIT_TIMER0_COMPARE_B_OUT   3'h5
`define PDAF_BIT_TIMER0_COMPARE_A_OUT   3'h6
`define PDAF_BIT_TIMER2_COMPARE_B_OUT   3'h3
`define PDAF_RST_BYTE   8'h00
`define PDAF_RST_RX     1'h1
`endif

// file: design/pdaf_pkg.sv
// port d alternate function override: shared types
// assumes pdaf_defs.svh sits beside it
`default_nettype none
package pdaf_pkg;
  // one override set for a single pin
  typedef struct packed {
    logic puoe;
    logic puov;
    logic ddoe;
    logic ddov;
    logic pvoe;
    logic pvov;
    logic dieoe;
  } pdaf_ovr_t;
endpackage
`default_nettype wire

// file: design/pdaf_pin_cell.sv
// one pin: merges port register settings with alternate overrides
// assumes overrides arrive already decoded, outputs are combinational
`default_nettype none
module pdaf_pin_cell
  import pdaf_pkg::*;
(
  // port register side
  input  wire logic              dir_bit,
  input  wire logic              val_bit,
  input  wire logic              pullup_off,
  // overrides
  input  wire pdaf_pkg::pdaf_ovr_t ovr,
  // resolved pin controls
  output logic                   oe,
  output logic                   out,
  output logic                   pull,
  output logic                   in_en
);
  import pdaf_pkg::*;

  logic dir_eff;
  // each override but dieoe picks its value, else the register bit stands; dieoe alone sets in_en
  always_comb begin
    dir_eff = ovr.ddoe ? ovr.ddov : dir_bit;
    oe      = dir_eff;
    out     = ovr.pvoe ? ovr.pvov : val_bit;
    pull    = ovr.puoe ? ovr.puov : (~dir_eff & val_bit & ~pullup_off);
    in_en   = ovr.dieoe;
  end
endmodule
`default_nettype wire

// file: design/pdaf_top.sv
// port d alternate function override: eight pins, registered pin controls
// every alternate function of the port either takes a pin over or listens to it
// assumes all inputs synchronous to ref_clk; one cycle of latency to the pins
// assumes the ordinary port registers and the peripherals live outside this block
// assumes the board side resolves drive, pull-up and float from the pin controls
`include "pdaf_defs.svh"
`default_nettype none
module pdaf_top
  import pdaf_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // ordinary port registers
  input  wire logic [7:0] port_dir,
  input  wire logic [7:0] port_val,
  input  wire logic       global_pullup_off,
  // timers
  input  wire logic       timer0_compare_a_en,
  input  wire logic       timer0_compare_a_out,
  input  wire logic       timer0_compare_b_en,
  input  wire logic       timer0_compare_b_out,
  input  wire logic       timer2_compare_b_en,
  input  wire logic       timer2_compare_b_out,
  output logic            timer0_count_input,
  output logic            timer1_count_input,
  // serial port
  input  wire logic       serial0_tx_enable,
  input  wire logic       serial0_transmit_line,
  input  wire logic       serial0_rx_enable,
  output logic            serial0_receive_line,
  input  wire logic       serial_mode_select,
  input  wire logic       serial0_clock_out,
  output logic            serial0_ext_clock,
  // interrupts
  input  wire logic       ext_irq_zero_en,
  input  wire logic       ext_irq_one_en,
  output logic            ext_irq_zero,
  output logic            ext_irq_one,
  input  wire logic [7:0] pin_change_mask,
  input  wire logic       pin_change_group1_en,
  input  wire logic       pin_change_group2_en,
  output logic [7:0]      pin_change_in,
  // board pins
  input  wire logic [7:0] pin_in,
  output logic [7:0]      pin_out,
  output logic [7:0]      pin_oe,
  output logic [7:0]      pin_pullup
);
  import pdaf_pkg::*;

  // ==========================================================
  // override decode
  pdaf_ovr_t  ovr [`PDAF_NPINS];
  logic [7:0] oe_c;
  logic [7:0] out_c;
  logic [7:0] pull_c;
  logic [7:0] ien_c;

  // pin-change buffer gate: source mask bit and its group enable
  function automatic logic pc_on(input logic msk, input logic grp);
    pc_on = msk & grp;
  endfunction

  // a compare unit reaches its pin only while the pin is an output,
  // so a parked timer never fights whatever the board puts on the pin
  function automatic logic cmp_drive(input logic en, input logic dir);
    cmp_drive = en & dir;
  endfunction

  always_comb begin
    // start from no override: an untouched field leaves the pin to its registers
    for (int i = 0; i < `PDAF_NPINS; i++) begin
      ovr[i] = '0;
      ovr[i].dieoe = pc_on(pin_change_mask[i], pin_change_group2_en);
    end

    // compare outputs reach the pin only when the direction bit is set
    ovr[`PDAF_BIT_TIMER0_COMPARE_A_OUT].pvoe = cmp_drive(timer0_compare_a_en, port_dir[`PDAF_BIT_TIMER0_COMPARE_A_OUT]);
    ovr[`PDAF_BIT_TIMER0_COMPARE_A_OUT].pvov = timer0_compare_a_out;
    ovr[`PDAF_BIT_TIMER0_COMPARE_B_OUT].pvoe = cmp_drive(timer0_compare_b_en, port_dir[`PDAF_BIT_TIMER0_COMPARE_B_OUT]);
    ovr[`PDAF_BIT_TIMER0_COMPARE_B_OUT].pvov = timer0_compare_b_out;
    ovr[`PDAF_BIT_TIMER2_COMPARE_B_OUT].pvoe = cmp_drive(timer2_compare_b_en, port_dir[`PDAF_BIT_TIMER2_COMPARE_B_OUT]);
    ovr[`PDAF_BIT_TIMER2_COMPARE_B_OUT].pvov = timer2_compare_b_out;

    // master mode puts the serial clock value on pin 4; the direction bit still
    // decides whether it leaves the chip, so in slave mode an output pin drives its value bit instead
    ovr[`PDAF_BIT_XCK].pvoe  = serial_mode_select;
    ovr[`PDAF_BIT_XCK].pvov  = serial0_clock_out;

    // interrupt inputs keep their buffers on even when pin change is idle
    ovr[`PDAF_BIT_IRQ1].dieoe = ext_irq_one_en |
                                pc_on(pin_change_mask[`PDAF_BIT_IRQ1], pin_change_group2_en);
    // the group 1 enable, not group 2, gates source 18 on this pin
    ovr[`PDAF_BIT_IRQ0].dieoe = ext_irq_zero_en |
                                pc_on(pin_change_mask[`PDAF_BIT_IRQ0], pin_change_group1_en);

    // transmitter owns pin 1 outright: output, transmit data, no pull-up
    ovr[`PDAF_BIT_TX].puoe = serial0_tx_enable;
    ovr[`PDAF_BIT_TX].puov = 1'h0;
    ovr[`PDAF_BIT_TX].ddoe = serial0_tx_enable;
    ovr[`PDAF_BIT_TX].ddov = 1'h1;
    ovr[`PDAF_BIT_TX].pvoe = serial0_tx_enable;
    ovr[`PDAF_BIT_TX].pvov = serial0_transmit_line;

    // receiver makes pin 0 an input but leaves the pull-up to the value bit
    ovr[`PDAF_BIT_RX].puoe = serial0_rx_enable;
    ovr[`PDAF_BIT_RX].ddoe = serial0_rx_enable;
    ovr[`PDAF_BIT_RX].ddov = 1'h0;
    ovr[`PDAF_BIT_RX].puov = port_val[`PDAF_BIT_RX] & ~global_pullup_off;
  end

  // ==========================================================
  // per-pin merge
  // every pin runs the same merge, so one cell type serves all eight
  genvar g;
  generate
    for (g = 0; g < `PDAF_NPINS; g++) begin : g_pin
      pdaf_pin_cell u_cell (
        .dir_bit    (port_dir[g]),
        .val_bit    (port_val[g]),
        .pullup_off (global_pullup_off),
        .ovr        (ovr[g]),
        .oe         (oe_c[g]),
        .out        (out_c[g]),
        .pull       (pull_c[g]),
        .in_en      (ien_c[g])
      );
    end
  endgenerate

  // ==========================================================
  // registered pin controls
  logic [7:0] oe_reg;
  logic [7:0] oe_next;
  logic [7:0] out_reg;
  logic [7:0] out_next;
  logic [7:0] pull_reg;
  logic [7:0] pull_next;

  // next pin controls are the merged cell outputs
  always_comb begin
    oe_next   = oe_c;
    out_next  = out_c;
    pull_next = pull_c;
  end

  // clock enable freezes the pins; reset releases every pin to input, no pull-up
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      oe_reg   <= `PDAF_RST_BYTE;
      out_reg  <= `PDAF_RST_BYTE;
      pull_reg <= `PDAF_RST_BYTE;
    end else if (clk_en) begin
      oe_reg   <= oe_next;
      out_reg  <= out_next;
      pull_reg <= pull_next;
    end
  end

  // ==========================================================
  // registered peripheral inputs; the input buffer only gates the interrupt
  // paths, a disabled buffer reads zero as a sleeping input buffer would
  logic [7:0] pc_reg;
  logic [7:0] pc_next;
  logic       t0_reg;
  logic       t0_next;
  logic       t1_reg;
  logic       t1_next;
  logic       rx_reg;
  logic       rx_next;
  logic       xck_reg;
  logic       xck_next;
  logic       i0_reg;
  logic       i0_next;
  logic       i1_reg;
  logic       i1_next;

  // count, clock and receive paths stay ungated so a sleeping group never stalls them
  always_comb begin
    pc_next  = pin_in & ien_c;
    t0_next  = pin_in[`PDAF_BIT_XCK];
    xck_next = pin_in[`PDAF_BIT_XCK];
    t1_next  = pin_in[`PDAF_BIT_TIMER0_COMPARE_B_OUT];
    i0_next  = pin_in[`PDAF_BIT_IRQ0] & ien_c[`PDAF_BIT_IRQ0];
    i1_next  = pin_in[`PDAF_BIT_IRQ1] & ien_c[`PDAF_BIT_IRQ1];
    rx_next  = pin_in[`PDAF_BIT_RX];
  end

  // the receive line leaves reset high, as an idle serial line would stand
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_reg  <= `PDAF_RST_BYTE;
      t0_reg  <= 1'h0;
      xck_reg <= 1'h0;
      t1_reg  <= 1'h0;
      i0_reg  <= 1'h0;
      i1_reg  <= 1'h0;
      rx_reg  <= `PDAF_RST_RX;
    end else if (clk_en) begin
      pc_reg  <= pc_next;
      t0_reg  <= t0_next;
      xck_reg <= xck_next;
      t1_reg  <= t1_next;
      i0_reg  <= i0_next;
      i1_reg  <= i1_next;
      rx_reg  <= rx_next;
    end
  end

  // ==========================================================
  // outputs come straight from the flops
  assign pin_oe               = oe_reg;
  assign pin_out              = out_reg;
  assign pin_pullup           = pull_reg;
  assign pin_change_in        = pc_reg;
  assign timer0_count_input   = t0_reg;
  assign serial0_ext_clock    = xck_reg;
  assign timer1_count_input   = t1_reg;
  assign ext_irq_zero         = i0_reg;
  assign ext_irq_one          = i1_reg;
  assign serial0_receive_line = rx_reg;
endmodule
`default_nettype wire

// file: verification/pdaf_board.sv
// board model: what the eight port pins see from outside the device
// assumes pin controls come straight from pdaf_top, one clock
`default_nettype none
module pdaf_board (
  // design side
  input  wire logic       ref_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  // board drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt_reg = 8'h55;
  // a floating pin flips every cycle so a stale value never passes
  always @(posedge ref_clk) flt_reg <= ~flt_reg;
  // device drive wins, then board drive, then pull-up or float
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | flt_reg));
endmodule
`default_nettype wire

// file: verification/pdaf_top_assertions.sv
// port d override checker: relations between pdaf_top inputs and pins
// assumes one clock domain; each effect lands one enabled edge later
`default_nettype none
module pdaf_top_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  // causes
  input wire logic [7:0] port_dir,
  input wire logic [7:0] port_val,
  input wire logic       global_pullup_off,
  input wire logic       timer0_compare_a_en,
  input wire logic       timer0_compare_a_out,
  input wire logic       timer0_compare_b_en,
  input wire logic       timer0_compare_b_out,
  input wire logic       serial0_tx_enable,
  input wire logic       serial0_transmit_line,
  input wire logic       serial0_rx_enable,
  input wire logic       pin_change_group2_en,
  input wire logic       ext_irq_one_en,
  input wire logic [7:0] pin_change_mask,
  input wire logic [7:0] pin_in,
  // effects
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_change_in,
  input wire logic       ext_irq_one,
  input wire logic       serial0_receive_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ========================================
  // pin overrides
  a_tx_force: assert property (clk_en && serial0_tx_enable |=> pin_oe[1] && !pin_pullup[1]
    && pin_out[1] == $past(serial0_transmit_line)) else $error("tx pin not forced");
  a_rx_input: assert property (clk_en && serial0_rx_enable |=> !pin_oe[0]
    && serial0_receive_line == $past(pin_in[0])) else $error("rx pin not input");
  a_rx_pullup: assert property (clk_en && serial0_rx_enable && !global_pullup_off
    |=> pin_pullup[0] == $past(port_val[0])) else $error("rx pull-up wrong");
  a_pud_all: assert property (clk_en && global_pullup_off |=> pin_pullup == 8'h00)
    else $error("pull-up not disabled");
  a_cmp_a_drive: assert property (clk_en && timer0_compare_a_en && port_dir[6]
    |=> pin_out[6] == $past(timer0_compare_a_out)) else $error("compare a missing");
  a_cmp_a_block: assert property (clk_en && !port_dir[6] |=> !pin_oe[6]
    && pin_out[6] == $past(port_val[6])) else $error("compare a leaked");
  a_dir_plain: assert property (clk_en && !serial0_tx_enable
    |=> pin_oe[1] == $past(port_dir[1])) else $error("direction not ordinary");
  a_pc_mask: assert property (clk_en && !pin_change_group2_en |=> pin_change_in[7:4] == 4'h0)
    else $error("pin change not masked");
  a_cmp_b_drive: assert property (clk_en && timer0_compare_b_en && port_dir[5]
    |=> pin_out[5] == $past(timer0_compare_b_out)) else $error("compare b missing");
  a_irq1_gate: assert property (clk_en && (ext_irq_one_en || (pin_change_mask[3] && pin_change_group2_en))
    |=> ext_irq_one == $past(pin_in[3])) else $error("irq one input gated");
endmodule
bind pdaf_top pdaf_top_checker pdaf_top_checker_i (.*);
`default_nettype wire

// file: verification/pdaf_tb_top.sv
// port d override bench: random pin settings against a reference model
// assumes pdaf_top, pdaf_board and the checker are compiled first
`default_nettype none
module pdaf_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, sys_rst, clk_en;
  logic [15:0] s;
  logic [7:0]  d, v, m, ee, ev, pi, po, poe, pu, pci, be, o, oe;
  logic [5:0]  q;
  logic [37:0] e, p, exq[$];
  int          num_errors, n_checks;
  wire  [37:0] g = {po, poe, pu, pci, q};
  // ========================================
  // design and board
  pdaf_top pdaf_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .port_dir(d), .port_val(v),
    .global_pullup_off(s[0]), .timer0_compare_a_en(s[1]), .timer0_compare_a_out(s[2]), .timer0_compare_b_en(s[3]),
    .timer0_compare_b_out(s[4]), .timer2_compare_b_en(s[5]), .timer2_compare_b_out(s[6]),
    .timer0_count_input(q[5]), .timer1_count_input(q[4]), .serial0_tx_enable(s[7]), .serial0_transmit_line(s[8]),
    .serial0_rx_enable(s[9]), .serial0_receive_line(q[3]), .serial_mode_select(s[10]), .serial0_clock_out(s[11]),
    .serial0_ext_clock(q[2]), .ext_irq_zero_en(s[12]), .ext_irq_one_en(s[13]), .ext_irq_zero(q[1]),
    .ext_irq_one(q[0]), .pin_change_mask(m), .pin_change_group1_en(s[14]), .pin_change_group2_en(s[15]),
    .pin_change_in(pci), .pin_in(pi), .pin_out(po), .pin_oe(poe), .pin_pullup(pu));
  pdaf_board pdaf_board_i (.ref_clk(ref_clk), .pin_out(po), .pin_oe(poe), .pin_pullup(pu), .ext_en(ee),
    .ext_val(ev), .pin_in(pi));
  // 100 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // drive one cycle, let the board settle, then note the expected pins
  task automatic step(input logic rst);
    @(posedge ref_clk);
    #1;
    sys_rst = rst;
    clk_en = rst | ($urandom % 8 != 0);
    {d, v, m, ee} = $urandom;
    {ev, s} = 24'($urandom);
    // now and then pins 6 and 7 serve the comparator: input, pull-up off
    if ($urandom % 4 == 0) {d[7:6], v[7:6]} = 4'h0;
    #1;
    oe = d;
    oe[1] |= s[7];
    oe[0] &= ~s[9];
    o = v;
    o[6] = (s[1] & d[6]) ? s[2] : v[6];
    o[5] = (s[3] & d[5]) ? s[4] : v[5];
    o[3] = (s[5] & d[3]) ? s[6] : v[3];
    o[4] = s[10] ? s[11] : v[4];
    o[1] = s[7] ? s[8] : v[1];
    be = m & {8{s[15]}};
    be[3] |= s[13];
    be[2] = s[12] | (m[2] & s[14]);
    if (rst) e = 38'h8;
    else if (clk_en) e = {o, oe, ~oe & v & {8{~s[0]}}, pi & be, pi[4], pi[5], pi[0], pi[4], pi[2] & be[2], pi[3] & be[3]};
    exq.push_back(e);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // monitor: oldest note against what the pins show now
  always @(posedge ref_clk) begin
    #1;
    if (exq.size() > 0) begin
      p = exq.pop_front();
      n_checks++;
      if (g !== p) begin
        num_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, p);
      end
    end
  end
  // main sequence; clk_en drops at random so held outputs are checked too
  initial begin
    {sys_rst, clk_en} = 2'h3;
    {s, d, v, m, ee, ev} = 56'h0;
    void'($urandom(99886));
    repeat (6) step(1'h1);
    $display("test reset done");
    repeat (400) step(1'h0);
    $display("test random_mix done");
    repeat (2) step(1'h1);
    repeat (200) step(1'h0);
    $display("test mid_reset done");
    repeat (3) @(posedge ref_clk);
    conclude();
  end
  // watchdog well beyond the 611 cycles the tests need
  initial begin
    #50000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
